// [inc/synth_cfg_pkg.sv]
// shared constants and types for the synthesizer configuration logic
package synth_cfg_pkg;

    // ------------------------------------------------------------------
    // configuration word, laid out exactly as the serial stream
    // ------------------------------------------------------------------
    localparam int SR_W = 14;
    localparam int M_W = 9;
    localparam int N_W = 2;
    localparam int T_W = 3;

    // test pin selections
    typedef enum logic [2:0] {
        TS_SR_OUT = 3'h0,
        TS_HIGH = 3'h1,
        TS_REF = 3'h2,
        TS_LOOP = 3'h3,
        TS_SYNTH = 3'h4,
        TS_LOW = 3'h5,
        TS_BYPASS = 3'h6,
        TS_SYNTH_DIV4 = 3'h7
    } test_sel_t;

    // test field in bits 13:11, output select 10:9, loop value 8:0
    typedef struct packed {
        test_sel_t t;
        logic [N_W-1:0] n;
        logic [M_W-1:0] m;
    } cfg_t;

    // ------------------------------------------------------------------
    // reset values and fixed divide counts
    // ------------------------------------------------------------------
    localparam cfg_t CFG_RST = '{t: TS_SR_OUT, n: 2'h0, m: 9'h1FF};
    localparam logic [SR_W-1:0] SR_RST = 14'h0000;
    localparam logic [M_W-1:0] XTAL_REF_DIV = 9'h008;
    localparam logic [M_W-1:0] SYNTH_TEST_DIV = 9'h004;
    localparam logic [M_W-1:0] OUT_DIV_BASE = 9'h002;
    localparam logic CTRL_RUN_RST = 1'b1;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CFG_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] SHIFT_OFS = 8'h08;
    localparam int CTRL_RUN_BIT = 0;

endpackage

// [hdl/tick_divider.sv]
// divide-by-count stage clocked by single-cycle input ticks
`timescale 1ns/100ps
`default_nettype none

module tick_divider
    import synth_cfg_pkg::*;
#(
    parameter int W = 9
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic [W-1:0] div,
    output logic pulse_q,
    output logic level_q
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic wrap;

    // wrap also when the count shrank below the current position
    assign wrap = (div != '0) && (cnt_q >= div - W'(1));

    // next count; a zero divide value parks the counter
    always_comb
    begin
        cnt_d = cnt_q;
        if (tick)
        begin
            if (div == '0 || wrap)
                cnt_d = '0;
            else
                cnt_d = cnt_q + W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    // one pulse per full count; level high for the first half gives 50% on even counts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pulse_q <= 1'b0;
            level_q <= 1'b0;
        end
        else
        begin
            pulse_q <= tick && wrap;
            level_q <= (div != '0) && (cnt_d < (div >> 1));
        end
    end

endmodule
`default_nettype wire

// [hdl/synth_divider_config_logic.sv]
// configuration latches, serial port, dividers and test mux of the synthesizer
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module synth_divider_config_logic
    import synth_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic xtal_tick,
    input wire logic core_tick,
    input wire logic s_clock,
    input wire logic s_data,
    input wire logic s_load,
    input wire logic p_load_n,
    input wire logic [M_W-1:0] m_pin,
    input wire logic [M_W-1:0] m_drive,
    input wire logic [N_W-1:0] n_pin,
    input wire logic [N_W-1:0] n_drive,
    output logic ref_tick,
    output logic fb_tick,
    output logic synth_out,
    output logic test_out
);

    // ------------------------------------------------------------------
    // internal state
    // ------------------------------------------------------------------
    cfg_t cfg_q;
    cfg_t cfg_d;
    logic [SR_W-1:0] shift_q;
    logic s_clock_prev_q;
    logic run_q;
    logic s_clk_rise;
    logic bypass;
    logic src_tick;
    logic [M_W-1:0] m_eff;
    logic [N_W-1:0] n_eff;
    logic [M_W-1:0] out_ratio;
    logic ref_level;
    logic loop_level;
    logic out_pulse;
    logic div4_level;
    logic apb_setup;
    logic apb_commit;
    logic [31:0] rdata_d;
    logic addr_ok;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------------
    // parallel pins and serial port
    // ------------------------------------------------------------------

    // pull-ups: a bit nobody drives reads as one
    assign m_eff = m_pin | ~m_drive;
    assign n_eff = n_pin | ~n_drive;

    // pins are synchronous, so one previous sample is enough for edges
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_clock_prev_q <= 1'b0;
        else
            s_clock_prev_q <= s_clock;
    end

    assign s_clk_rise = s_clock && !s_clock_prev_q;

    // first bit shifted in ends at bit 13, so fields land msb on top
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shift_q <= SR_RST;
        else if (s_clk_rise)
            shift_q <= {shift_q[SR_W-2:0], s_data};
    end

    // ------------------------------------------------------------------
    // configuration latches
    // ------------------------------------------------------------------

    // modelled as sampled-transparent: they follow their source each cycle
    // the source is open, so the value of the last open cycle is what the
    // closing edge leaves behind
    always_comb
    begin
        cfg_d = cfg_q;
        if (!p_load_n)
        begin
            // parallel path wins and never sets a test code
            cfg_d.m = m_eff;
            cfg_d.n = n_eff;
            cfg_d.t = TS_SR_OUT;
        end
        else if (s_load)
        begin
            cfg_d = cfg_t'(shift_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cfg_q <= CFG_RST;
        else
            cfg_q <= cfg_d;
    end

    // ------------------------------------------------------------------
    // dividers
    // ------------------------------------------------------------------

    // bypass lets a board tester step the loop and output dividers from the serial clock
    assign bypass = (cfg_q.t == TS_BYPASS);
    assign src_tick = run_q && (bypass ? s_clk_rise : core_tick);
    assign out_ratio = OUT_DIV_BASE << cfg_q.n;

    tick_divider #(.W(M_W)) ref_div
    (
        .pclk(pclk),
        .presetn(presetn),
        .tick(run_q && xtal_tick),
        .div(XTAL_REF_DIV),
        .pulse_q(ref_tick),
        .level_q(ref_level)
    );

    // loop level is only balanced for even values, which is acceptable
    tick_divider #(.W(M_W)) loop_div
    (
        .pclk(pclk),
        .presetn(presetn),
        .tick(src_tick),
        .div(cfg_q.m),
        .pulse_q(fb_tick),
        .level_q(loop_level)
    );

    tick_divider #(.W(M_W)) out_div
    (
        .pclk(pclk),
        .presetn(presetn),
        .tick(src_tick),
        .div(out_ratio),
        .pulse_q(out_pulse),
        .level_q(synth_out)
    );

    // each output wrap is one rising edge of the synthesizer output
    tick_divider #(.W(M_W)) test_div
    (
        .pclk(pclk),
        .presetn(presetn),
        .tick(out_pulse),
        .div(SYNTH_TEST_DIV),
        .pulse_q(),
        .level_q(div4_level)
    );

    // ------------------------------------------------------------------
    // test pin
    // ------------------------------------------------------------------

    // registered so the pin carries no glitch while the code changes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            test_out <= 1'b0;
        else
        begin
            case (cfg_q.t)
                TS_SR_OUT: test_out <= shift_q[SR_W-1];
                TS_HIGH: test_out <= 1'b1;
                TS_REF: test_out <= ref_level;
                TS_LOOP: test_out <= loop_level;
                TS_SYNTH: test_out <= synth_out;
                TS_LOW: test_out <= 1'b0;
                TS_BYPASS: test_out <= loop_level;
                TS_SYNTH_DIV4: test_out <= div4_level;
                default: test_out <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // apb slave: one wait state, error on unmapped addresses
    // ------------------------------------------------------------------
    assign apb_setup = psel && penable && !pready;
    assign apb_commit = psel && penable && pready;

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        addr_ok = 1'b1;
        case (paddr)
            CTRL_OFS: rdata_d[CTRL_RUN_BIT] = run_q;
            CFG_OFS: rdata_d[SR_W-1:0] = cfg_q;
            SHIFT_OFS: rdata_d[SR_W-1:0] = shift_q;
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= apb_setup;
            pslverr <= apb_setup && !addr_ok;
            if (apb_setup && !pwrite)
                prdata <= rdata_d;
        end
    end

    // run gates every divider; configuration keeps tracking while stopped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_q <= CTRL_RUN_RST;
        else if (apb_commit && pwrite && paddr == CTRL_OFS)
            run_q <= pwdata[CTRL_RUN_BIT];
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    par_capture_a: assert property (!p_load_n |=> cfg_q.m == $past(m_eff))
        else $error("loop value does not follow parallel pins");

    test_force_a: assert property (!p_load_n |=> cfg_q.t == TS_SR_OUT)
        else $error("test field not forced while parallel load low");

    par_priority_a: assert property ((!p_load_n && s_load) |=> cfg_q.n == $past(n_eff))
        else $error("serial path overrode parallel load");

    ser_follow_a: assert property ((p_load_n && s_load) |=> cfg_q == $past(shift_q))
        else $error("latches do not follow shift register");

    latch_hold_a: assert property ((p_load_n && !s_load) |=> $stable(cfg_q))
        else $error("latches changed while both loads idle");

    shift_step_a: assert property (s_clk_rise |=>
        shift_q == {$past(shift_q[SR_W-2:0]), $past(s_data)})
        else $error("shift register did not advance on serial clock");

    pullup_read_a: assert property ((!p_load_n && m_drive == '0) |=> cfg_q.m == 9'h1FF)
        else $error("undriven loop pins not read as ones");

    test_high_a: assert property ((cfg_q.t == TS_HIGH) [*2] |-> test_out)
        else $error("test pin not high for code 001");

    test_low_a: assert property ((cfg_q.t == TS_LOW) [*2] |-> !test_out)
        else $error("test pin not low for code 101");

    bypass_src_a: assert property ((bypass && run_q && !s_clk_rise) |=> !fb_tick)
        else $error("loop counter fired without serial clock in bypass");

endmodule
`default_nettype wire

// [dv/host_cfg_model.sv]
// host model driving the serial and parallel configuration pins
`timescale 1ns/100ps
`default_nettype none

module host_cfg_model
    import synth_cfg_pkg::*;
(
    input wire logic pclk,
    output logic s_clock,
    output logic s_data,
    output logic s_load,
    output logic p_load_n,
    output logic [M_W-1:0] m_pin,
    output logic [M_W-1:0] m_drive,
    output logic [N_W-1:0] n_pin,
    output logic [N_W-1:0] n_drive
);
    // serial lines stand still between frames; pins start undriven
    initial
    begin
        s_clock = 1'h0;
        s_data = 1'h0;
        s_load = 1'h0;
        p_load_n = 1'h1;
        m_pin = 9'h000;
        m_drive = 9'h000;
        n_pin = 2'h0;
        n_drive = 2'h0;
    end

    // shift one word in, msb of each field first, then strobe the latches
    task automatic send_word(input cfg_t w);
        for (int i = SR_W-1; i >= 0; i--)
        begin
            @(posedge pclk);
            s_clock <= 1'h0;
            s_data <= w[i];
            @(posedge pclk);
            s_clock <= 1'h1;
        end
        @(posedge pclk);
        s_clock <= 1'h0;
        s_data <= ~w[0]; // data no longer held, so show the wrong level
        @(posedge pclk);
        s_load <= 1'h1;
        @(posedge pclk);
        s_load <= 1'h0;
    endtask

    // bare serial clock pulses, used as the divider source in bypass
    task automatic pulse_clock(input int k);
        repeat (k)
        begin
            @(posedge pclk);
            s_clock <= 1'h1;
            @(posedge pclk);
            s_clock <= 1'h0;
        end
    endtask

    // parallel load; undriven pins carry the inverse so only pull-ups help
    task automatic par_load(input cfg_t v, input logic [M_W-1:0] md,
                            input logic [N_W-1:0] nd, input logic sl);
        @(posedge pclk);
        p_load_n <= 1'h0;
        s_load <= sl;
        m_drive <= md;
        n_drive <= nd;
        m_pin <= v.m ^ ~md;
        n_pin <= v.n ^ ~nd;
        repeat (2) @(posedge pclk);
        p_load_n <= 1'h1;
        s_load <= 1'h0;
        @(posedge pclk);
        m_drive <= 9'h000;
        n_drive <= 2'h0;
        m_pin <= ~m_pin;
        n_pin <= ~n_pin;
    endtask
endmodule
`default_nettype wire

// [dv/synth_divider_config_logic_tb.sv]
// self-checking bench for the synthesizer configuration logic
`timescale 1ns/100ps
`default_nettype none

module synth_divider_config_logic_tb
    import synth_cfg_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, xtal_tick, core_tick;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, ref_tick, fb_tick, synth_out, test_out;
    logic s_clock, s_data, s_load, p_load_n;
    logic [M_W-1:0] m_pin, m_drive, md;
    logic [N_W-1:0] n_pin, n_drive, nd;
    logic [32:0] exp_q[$];
    logic ck_d = 1'h0;
    logic so_d = 1'h0;
    logic to_d = 1'h0;
    int bad_count, num_checks;
    int cnt[5] = '{default: 0};
    int b[5];
    cfg_t w;

    // ------------------------------------------------------------------
    // clock, design and host model
    // ------------------------------------------------------------------
    initial
    begin
        pclk = 1'h0;
        forever #2.5 pclk = ~pclk;
    end

    synth_divider_config_logic synth_divider_config_logic_inst (.pclk, .presetn,
        .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .xtal_tick, .core_tick, .s_clock, .s_data, .s_load, .p_load_n, .m_pin,
        .m_drive, .n_pin, .n_drive, .ref_tick, .fb_tick, .synth_out, .test_out);

    host_cfg_model host_cfg_model_inst (.pclk, .s_clock, .s_data, .s_load,
        .p_load_n, .m_pin, .m_drive, .n_pin, .n_drive);

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [32:0] seen, input logic [32:0] want);
        num_checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask

    // one apb transfer; a read notes {pslverr, prdata} expected
    task automatic apb(input logic [7:0] a, input logic wr, input logic [32:0] e);
        @(posedge pclk);
        paddr <= a;
        pwrite <= wr;
        pwdata <= e[31:0];
        psel <= 1'h1;
        if (!wr)
            exp_q.push_back(e);
        @(posedge pclk);
        penable <= 1'h1;
        // hold the request until ready; only the watchdog ends a hang
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // k one-cycle ticks of crystal (x=1) or core (x=0), then let outputs settle
    task automatic ticks(input logic x, input int k);
        @(posedge pclk);
        xtal_tick <= x;
        core_tick <= !x;
        repeat (k) @(posedge pclk);
        xtal_tick <= 1'h0;
        core_tick <= 1'h0;
        repeat (3) @(posedge pclk);
    endtask

    function automatic logic [32:0] dif(input int i);
        return 33'(cnt[i] - b[i]);
    endfunction

    task automatic wrap_up();
        if (exp_q.size() != 0)
            bad_count++;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // output monitor: event counts, and read results against the oldest note
    always @(posedge pclk)
    begin
        ck_d <= core_tick;
        so_d <= synth_out;
        to_d <= test_out;
        cnt[0] <= cnt[0] + int'(ref_tick);
        cnt[1] <= cnt[1] + int'(fb_tick);
        cnt[2] <= cnt[2] + int'(synth_out && !so_d);
        cnt[3] <= cnt[3] + int'(ck_d && synth_out);
        cnt[4] <= cnt[4] + int'(test_out && !to_d);
        if (psel && penable && pready && !pwrite)
            chk({pslverr, prdata}, exp_q.pop_front());
    end

    // watchdog, far beyond the fewer than a thousand cycles the run needs
    initial
    begin
        #100000;
        bad_count++;
        wrap_up();
    end

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial
    begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        xtal_tick = 1'h0;
        core_tick = 1'h0;
        void'($urandom(93478));
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        apb(CTRL_OFS, 1'h0, 33'h000000001);
        apb(CFG_OFS, 1'h0, 33'(CFG_RST));
        apb(SHIFT_OFS, 1'h0, 33'(SR_RST));
        apb(8'h0C, 1'h0, 33'h100000000);
        $display("test reset done");
        // every test code through the serial port
        for (int t = 0; t < 8; t++)
        begin
            w = cfg_t'({3'(t), 11'($urandom)});
            host_cfg_model_inst.send_word(w);
            apb(SHIFT_OFS, 1'h0, 33'(w));
            apb(CFG_OFS, 1'h0, 33'(w));
            if (t == 0 || t == 1 || t == 5)
                chk(33'(test_out), 33'(t == 1));
        end
        $display("test serial done");
        // bypass: serial clock feeds both dividers, core ticks held high and ignored
        host_cfg_model_inst.send_word(cfg_t'({3'h6, 2'h0, 9'h004}));
        // let the code change settle so no stale edge lands in the window
        repeat (4) @(posedge pclk);
        b = cnt;
        core_tick <= 1'h1; // core ticks must be ignored in bypass
        host_cfg_model_inst.pulse_clock(8);
        core_tick <= 1'h0;
        repeat (3) @(posedge pclk);
        chk(dif(2), 33'h4);
        chk(dif(4), 33'h2);
        $display("test bypass done");
        // parallel load over a strobe held high, test field left random
        w = cfg_t'(14'($urandom));
        md = 9'($urandom);
        nd = 2'($urandom);
        host_cfg_model_inst.par_load(w, md, nd, 1'h1);
        apb(CFG_OFS, 1'h0, 33'({3'h0, w.n | ~nd, w.m | ~md}));
        $display("test parallel done");
        // power-up load inside the lock range, then a one-step serial retune
        w = cfg_t'({3'h0, 2'h0, 9'(200 + $urandom_range(199))});
        host_cfg_model_inst.par_load(w, 9'h1FF, 2'h3, 1'h0);
        apb(CFG_OFS, 1'h0, 33'(w));
        w.m = w.m + 9'h001;
        host_cfg_model_inst.send_word(w);
        apb(CFG_OFS, 1'h0, 33'(w));
        $display("test retune done");
        // loop divider at 8, output divider over all four ratios
        for (int n = 0; n < 4; n++)
        begin
            host_cfg_model_inst.par_load(cfg_t'({3'h0, 2'(n), 9'h008}), 9'h1FF, 2'h3, 1'h0);
            // a ratio change moves the output level without a tick; keep it out
            repeat (2) @(posedge pclk);
            b = cnt;
            ticks(1'h0, 64);
            chk(dif(1), 33'h8);
            chk(dif(2), 33'(32 >> n));
            chk(dif(3), 33'h20);
        end
        b = cnt;
        ticks(1'h1, 64);
        chk(dif(0), 33'h8);
        // run bit cleared: ticks must be ignored
        apb(CTRL_OFS, 1'h1, 33'h0);
        b = cnt;
        ticks(1'h1, 64);
        chk(dif(0), 33'h0);
        apb(CTRL_OFS, 1'h0, 33'h0);
        apb(CTRL_OFS, 1'h1, 33'h1);
        $display("test dividers done");
        wrap_up();
    end
endmodule
`default_nettype wire
